// ===== design/rcf_pkg.sv
// Package: register map, field layout and constants for the retimer path block
package rcf_pkg;

   // ****************************************************************
   // Register indices (word addresses on the register bus)
   // ****************************************************************
   localparam logic [7:0] IDX_TX_MAIN_TAP  = 8'h3d;
   localparam logic [7:0] IDX_TX_PRE_TAP   = 8'h3e;
   localparam logic [7:0] IDX_TX_POST_TAP  = 8'h3f;
   localparam logic [7:0] IDX_PATH_CTRL    = 8'h40;
   localparam logic [7:0] IDX_RATE_LO      = 8'h41;
   localparam logic [7:0] IDX_RATE_HI      = 8'h42;
   localparam logic [7:0] IDX_CDR_STATUS   = 8'h43;
   localparam logic [7:0] IDX_PPM_COUNT    = 8'h44;

   // ****************************************************************
   // Tap field layout and limits
   // ****************************************************************
   localparam int         TAP_SIGN_BIT     = 6;
   localparam logic [5:0] MAIN_MAG_MAX     = 6'h1f;
   localparam logic [5:0] SIDE_MAG_MAX     = 6'h0f;
   localparam logic [7:0] MAIN_TAP_RESET   = 8'h00;
   localparam logic [7:0] SIDE_TAP_RESET   = 8'h00;

   // ****************************************************************
   // Path control fields
   // ****************************************************************
   localparam int         CTRL_OUT_LSB     = 0;
   localparam int         CTRL_IN_BIT      = 2;
   localparam int         CTRL_CHK_BIT     = 3;
   localparam int         CTRL_MANUAL_BIT  = 4;
   localparam int         CTRL_IDX_LSB     = 5;
   localparam logic [6:0] PATH_CTRL_RESET  = 7'h00;

   typedef enum logic [1:0] {
      RCF_OUT_RETIMED = 2'b00,
      RCF_OUT_RAW     = 2'b01,
      RCF_OUT_PATGEN  = 2'b10,
      RCF_OUT_MUTE    = 2'b11
   } rcf_out_sel_e;

   typedef enum logic {
      RCF_IN_EQ     = 1'b0,
      RCF_IN_PATGEN = 1'b1
   } rcf_in_sel_e;

   // ****************************************************************
   // Frequency-offset counter
   // ****************************************************************
   localparam int          CNT_W           = 16;
   localparam int          CAL_WINDOW      = 64;
   localparam logic [15:0] MANUAL_LO_RESET = 16'h0000;
   localparam logic [15:0] MANUAL_HI_RESET = 16'hffff;
   // Rate table: recovered-clock ticks per window, low and high bounds
   localparam logic [15:0] RATE_LO_TAB [4] = '{16'h01f0, 16'h00f8, 16'h007c, 16'h003e};
   localparam logic [15:0] RATE_HI_TAB [4] = '{16'h0210, 16'h0108, 16'h0084, 16'h0042};

endpackage

// ===== design/rcf_ppm_counter.sv
// Frequency-offset counter paced by the calibration clock
`timescale 1ns/1ps
module rcf_ppm_counter
   import rcf_pkg::*;
#(
   parameter int WINDOW = CAL_WINDOW
) (
   input  wire logic               clk,
   input  wire logic               rst,
   input  wire logic               cal_clk_pin,
   input  wire logic               rec_tick,
   input  wire logic [CNT_W-1:0]   range_lo,
   input  wire logic [CNT_W-1:0]   range_hi,
   output logic      [CNT_W-1:0]   last_count,
   output logic                    in_range
);

   // ****************************************************************
   // Calibration clock sampling
   // ****************************************************************
   logic       cal_meta;
   logic       cal_sync;
   logic       cal_prev;
   logic [$clog2(WINDOW+1)-1:0] cal_edges;
   logic [CNT_W-1:0] tick_count;
   logic       window_end;

   // The calibration clock only paces this window; it never touches the data path
   always_ff @(posedge clk) begin
      if (rst) begin
         cal_meta <= 1'b0;
         cal_sync <= 1'b0;
         cal_prev <= 1'b0;
      end else begin
         cal_meta <= cal_clk_pin;
         cal_sync <= cal_meta;
         cal_prev <= cal_sync;
      end
   end

   assign window_end = cal_sync && !cal_prev &&
                       (cal_edges == ($clog2(WINDOW+1))'(WINDOW - 1));

   // ****************************************************************
   // Window and tick counting
   // ****************************************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         cal_edges  <= '0;
         tick_count <= '0;
         last_count <= '0;
      end else begin
         if (cal_sync && !cal_prev) begin
            cal_edges <= window_end ? '0 : cal_edges + 1'b1;
         end
         if (window_end) begin
            last_count <= tick_count + CNT_W'(rec_tick);
            tick_count <= '0;
         end else if (rec_tick && tick_count != '1) begin
            tick_count <= tick_count + 1'b1;
         end
      end
   end

   // Lock is only permitted while the measured rate sits inside the range
   always_ff @(posedge clk) begin
      if (rst) begin
         in_range <= 1'b0;
      end else if (window_end) begin
         in_range <= (tick_count + CNT_W'(rec_tick) >= range_lo) &&
                     (tick_count + CNT_W'(rec_tick) <= range_hi);
      end
   end

endmodule

// ===== design/rcf_retimer_path.sv
// Retimer channel path: recovery muxes, rate limit and three-tap transmit FIR
//
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
module rcf_retimer_path
   import rcf_pkg::*;
#(
   parameter int WINDOW = CAL_WINDOW
) (
   input  wire logic               clk,
   input  wire logic               rst,
   // Register bus
   input  wire logic [7:0]         avs_address,
   input  wire logic               avs_read,
   input  wire logic               avs_write,
   input  wire logic [31:0]        avs_writedata,
   output logic      [31:0]        avs_readdata,
   output logic                    avs_waitrequest,
   // Serial bit stream, one bit per recovered clock tick
   input  wire logic               rx_eq_data,
   input  wire logic               rx_raw_data,
   input  wire logic               patgen_data,
   input  wire logic               rec_tick,
   input  wire logic               cdr_lock_detect,
   input  wire logic               cal_clk_in,
   // Transmit side
   output logic                    tx_data,
   output logic                    tx_valid,
   output logic signed [7:0]       tx_fir_level,
   output logic                    tx_mute,
   output logic      [5:0]         output_swing_pkpk,
   output logic      [5:0]         output_swing_lf,
   // Pattern checker side
   output logic                    chk_data,
   output logic                    chk_valid,
   // Status
   output logic                    cdr_locked
);

   // ****************************************************************
   // Helpers
   // ****************************************************************
   // Sign bit kept, magnitude clipped to the tap's limit; bit 7 dropped
   function automatic logic [7:0] sat_tap(input logic [7:0] wr, input logic [5:0] max);
      logic [5:0] mag;
      mag = wr[5:0];
      if (mag > max) begin
         mag = max;
      end
      return {1'b0, wr[TAP_SIGN_BIT], mag};
   endfunction

   function automatic logic signed [7:0] tap_term(input logic [7:0] tap, input logic bit_v);
      logic signed [7:0] mag;
      mag = {2'b00, tap[5:0]};
      // A one bit drives +coef, a zero bit -coef; sign bit flips it
      return (tap[TAP_SIGN_BIT] ^ ~bit_v) ? -mag : mag;
   endfunction

   // ****************************************************************
   // Registers
   // ****************************************************************
   logic [7:0]       main_tap;
   logic [7:0]       pre_tap;
   logic [7:0]       post_tap;
   logic [6:0]       path_ctrl;
   logic [15:0]      manual_lo;
   logic [15:0]      manual_hi;
   logic             bus_take;
   logic             wr_take;
   logic [31:0]      next_readdata;
   logic [CNT_W-1:0] ppm_count;
   logic             freq_ok;

   rcf_out_sel_e     out_sel;
   rcf_in_sel_e      in_sel;
   logic             chk_en;
   logic             rate_manual;
   logic [1:0]       rate_idx;

   assign out_sel     = rcf_out_sel_e'(path_ctrl[CTRL_OUT_LSB +: 2]);
   assign in_sel      = rcf_in_sel_e'(path_ctrl[CTRL_IN_BIT]);
   assign chk_en      = path_ctrl[CTRL_CHK_BIT];
   assign rate_manual = path_ctrl[CTRL_MANUAL_BIT];
   assign rate_idx    = path_ctrl[CTRL_IDX_LSB +: 2];

   // One wait cycle, then the answer; a write lands on the edge waitrequest is low
   assign bus_take = (avs_read || avs_write) && avs_waitrequest;
   assign wr_take  = avs_write && !avs_waitrequest;

   always_ff @(posedge clk) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= !bus_take;
      end
   end

   always_comb begin
      next_readdata = 32'h0000_0000;
      if (avs_address == IDX_TX_MAIN_TAP) begin
         next_readdata[7:0] = main_tap;
      end else if (avs_address == IDX_TX_PRE_TAP) begin
         next_readdata[7:0] = pre_tap;
      end else if (avs_address == IDX_TX_POST_TAP) begin
         next_readdata[7:0] = post_tap;
      end else if (avs_address == IDX_PATH_CTRL) begin
         next_readdata[6:0] = path_ctrl;
      end else if (avs_address == IDX_RATE_LO) begin
         next_readdata[15:0] = manual_lo;
      end else if (avs_address == IDX_RATE_HI) begin
         next_readdata[15:0] = manual_hi;
      end else if (avs_address == IDX_CDR_STATUS) begin
         next_readdata[1:0] = {cdr_locked, freq_ok};
      end else if (avs_address == IDX_PPM_COUNT) begin
         next_readdata[CNT_W-1:0] = ppm_count;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         avs_readdata <= 32'h0000_0000;
      end else if (bus_take && avs_read) begin
         avs_readdata <= next_readdata;
      end
   end

   // Out-of-range coefficients are clipped rather than refused
   always_ff @(posedge clk) begin
      if (rst) begin
         main_tap <= MAIN_TAP_RESET;
         pre_tap  <= SIDE_TAP_RESET;
         post_tap <= SIDE_TAP_RESET;
      end else if (wr_take) begin
         if (avs_address == IDX_TX_MAIN_TAP) begin
            main_tap <= sat_tap(avs_writedata[7:0], MAIN_MAG_MAX);
         end else if (avs_address == IDX_TX_PRE_TAP) begin
            pre_tap <= sat_tap(avs_writedata[7:0], SIDE_MAG_MAX);
         end else if (avs_address == IDX_TX_POST_TAP) begin
            post_tap <= sat_tap(avs_writedata[7:0], SIDE_MAG_MAX);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         path_ctrl <= PATH_CTRL_RESET;
         manual_lo <= MANUAL_LO_RESET;
         manual_hi <= MANUAL_HI_RESET;
      end else if (wr_take) begin
         if (avs_address == IDX_PATH_CTRL) begin
            path_ctrl <= avs_writedata[6:0];
         end else if (avs_address == IDX_RATE_LO) begin
            manual_lo <= avs_writedata[15:0];
         end else if (avs_address == IDX_RATE_HI) begin
            manual_hi <= avs_writedata[15:0];
         end
      end
   end

   // ****************************************************************
   // Rate limit
   // ****************************************************************
   logic [CNT_W-1:0] range_lo;
   logic [CNT_W-1:0] range_hi;

   assign range_lo = rate_manual ? manual_lo : RATE_LO_TAB[rate_idx];
   assign range_hi = rate_manual ? manual_hi : RATE_HI_TAB[rate_idx];

   rcf_ppm_counter #(
      .WINDOW     (WINDOW)
   ) u_ppm (
      .clk        (clk),
      .rst        (rst),
      .cal_clk_pin(cal_clk_in),
      .rec_tick   (rec_tick),
      .range_lo   (range_lo),
      .range_hi   (range_hi),
      .last_count (ppm_count),
      .in_range   (freq_ok)
   );

   // A detector claiming lock outside the programmed range is not believed
   always_ff @(posedge clk) begin
      if (rst) begin
         cdr_locked <= 1'b0;
      end else begin
         cdr_locked <= cdr_lock_detect && freq_ok;
      end
   end

   // ****************************************************************
   // Recovery stage muxes
   // ****************************************************************
   logic rx_meta;
   logic rx_bit;
   logic raw_meta;
   logic raw_bit;
   logic retimed;
   logic cdr_out;
   logic cdr_in;

   // Both serial inputs are off-domain: two flops before use
   always_ff @(posedge clk) begin
      if (rst) begin
         rx_meta  <= 1'b0;
         rx_bit   <= 1'b0;
         raw_meta <= 1'b0;
         raw_bit  <= 1'b0;
      end else begin
         rx_meta  <= rx_eq_data;
         rx_bit   <= rx_meta;
         raw_meta <= rx_raw_data;
         raw_bit  <= raw_meta;
      end
   end

   assign cdr_in = (in_sel == RCF_IN_EQ) ? rx_bit : patgen_data;

   // Retiming happens on the recovered clock tick
   always_ff @(posedge clk) begin
      if (rst) begin
         retimed <= 1'b0;
      end else if (rec_tick) begin
         retimed <= cdr_in;
      end
   end

   always_comb begin
      case (out_sel)
         RCF_OUT_RETIMED: cdr_out = retimed;
         RCF_OUT_RAW:     cdr_out = raw_bit;
         RCF_OUT_PATGEN:  cdr_out = patgen_data;
         default:         cdr_out = 1'b0;
      endcase
   end

   // Checker sees the recovered clock and data, independent of output source
   always_ff @(posedge clk) begin
      if (rst) begin
         chk_data  <= 1'b0;
         chk_valid <= 1'b0;
      end else begin
         chk_data  <= chk_en ? retimed : 1'b0;
         chk_valid <= chk_en && rec_tick;
      end
   end

   // ****************************************************************
   // Transmit FIR
   // ****************************************************************
   // bit_hist[0] is the next bit, [1] the current one, [2] the previous one
   logic [2:0]        bit_hist;
   logic signed [7:0] next_level;

   always_ff @(posedge clk) begin
      if (rst) begin
         bit_hist <= 3'b000;
      end else if (rec_tick) begin
         bit_hist <= {bit_hist[1:0], cdr_out};
      end
   end

   // Precursor looks one bit ahead, postcursor one bit behind
   assign next_level = tap_term(pre_tap, bit_hist[0])  +
                       tap_term(main_tap, bit_hist[1]) +
                       tap_term(post_tap, bit_hist[2]);

   always_ff @(posedge clk) begin
      if (rst) begin
         tx_data      <= 1'b0;
         tx_valid     <= 1'b0;
         tx_mute      <= 1'b0;
         tx_fir_level <= 8'sh00;
      end else begin
         tx_data      <= bit_hist[1];
         tx_valid     <= rec_tick;
         tx_mute      <= (out_sel == RCF_OUT_MUTE);
         tx_fir_level <= (out_sel == RCF_OUT_MUTE) ? 8'sh00 : next_level;
      end
   end

   // Clipped fields keep each sum within six bits
   always_ff @(posedge clk) begin
      if (rst) begin
         output_swing_pkpk <= 6'h00;
         output_swing_lf   <= 6'h00;
      end else begin
         output_swing_pkpk <= pre_tap[5:0] + main_tap[5:0] + post_tap[5:0];
         output_swing_lf   <= main_tap[5:0];
      end
   end

endmodule

// ===== bench/rcf_retimer_path_properties.sv
// Checker of bus, stream and status relations at the retimer path ports
`timescale 1ns/1ps
module rcf_retimer_path_properties
   import rcf_pkg::*;
#(
   parameter int WINDOW = CAL_WINDOW
) (
   input wire logic              clk,
   input wire logic              rst,
   input wire logic [7:0]        avs_address,
   input wire logic              avs_read,
   input wire logic              avs_write,
   input wire logic [31:0]       avs_writedata,
   input wire logic [31:0]       avs_readdata,
   input wire logic              avs_waitrequest,
   input wire logic              rx_eq_data,
   input wire logic              rx_raw_data,
   input wire logic              patgen_data,
   input wire logic              rec_tick,
   input wire logic              cdr_lock_detect,
   input wire logic              cal_clk_in,
   input wire logic              tx_data,
   input wire logic              tx_valid,
   input wire logic signed [7:0] tx_fir_level,
   input wire logic              tx_mute,
   input wire logic [5:0]        output_swing_pkpk,
   input wire logic [5:0]        output_swing_lf,
   input wire logic              chk_data,
   input wire logic              chk_valid,
   input wire logic              cdr_locked
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence req_seen;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence answered;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   chk_bus_answer: assert property (req_seen |=> answered)
      else $error("bus answer missing");
   chk_wait_cause: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
      else $error("bus answer without request");
   chk_tick_valid: assert property (rec_tick |=> tx_valid)
      else $error("tick without valid");
   chk_valid_cause: assert property (tx_valid |-> $past(rec_tick))
      else $error("valid without tick");
   chk_mute_zero: assert property (tx_mute && tx_valid |-> tx_fir_level == 8'sh00)
      else $error("muted level not zero");
   chk_route_cause: assert property (chk_valid |-> $past(rec_tick))
      else $error("checker valid without tick");
   chk_swing_order: assert property (output_swing_lf <= output_swing_pkpk
      && output_swing_pkpk <= 6'h3d)
      else $error("swing order broken");
   chk_lf_range: assert property (output_swing_lf <= 6'h1f)
      else $error("main swing out of range");
   chk_lock_gate: assert property (cdr_locked |-> $past(cdr_lock_detect))
      else $error("lock without detector");
endmodule

bind rcf_retimer_path rcf_retimer_path_properties #(.WINDOW(WINDOW)) u_props (
   .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .rx_eq_data(rx_eq_data), .rx_raw_data(rx_raw_data),
   .patgen_data(patgen_data), .rec_tick(rec_tick), .cdr_lock_detect(cdr_lock_detect),
   .cal_clk_in(cal_clk_in), .tx_data(tx_data), .tx_valid(tx_valid),
   .tx_fir_level(tx_fir_level), .tx_mute(tx_mute), .output_swing_pkpk(output_swing_pkpk),
   .output_swing_lf(output_swing_lf), .chk_data(chk_data), .chk_valid(chk_valid),
   .cdr_locked(cdr_locked));

// ===== bench/rcf_link_partner.sv
// Far-side model: serial source, recovered ticks, lock detector and calibration clock
`timescale 1ns/1ps
module rcf_link_partner (
   input wire logic clk,
   input wire logic slow,
   input wire logic raw_level,
   input wire logic lock_in,
   output logic     rx_eq_data,
   output logic     rx_raw_data,
   output logic     rec_tick,
   output logic     cal_clk_in,
   output logic     cdr_lock_detect
);
   logic [1:0] cal_cnt = 2'h0;
   logic [1:0] gap     = 2'h0;
   logic [3:0] lfsr    = 4'h9;
   initial cal_clk_in = 1'b0;
   // Free running: a host clock does not stop for reset, 8 system periods = 25 MHz
   always @(posedge clk) begin
      cal_cnt <= cal_cnt + 2'h1;
      if (cal_cnt == 2'h3) cal_clk_in <= ~cal_clk_in;
   end
   // Slow mode spaces ticks three cycles apart to stall the stream
   always @(posedge clk) begin
      gap <= (gap == 2'h2) ? 2'h0 : gap + 2'h1;
      rec_tick <= !slow || gap == 2'h2;
      lfsr <= {lfsr[2:0], lfsr[3] ^ lfsr[2]};
      rx_eq_data <= lfsr[0];
      rx_raw_data <= raw_level;
      cdr_lock_detect <= lock_in;
   end
endmodule

// ===== bench/tb.sv
// Self-checking testbench for the retimer path block
`timescale 1ns/1ps
module tb
   import rcf_pkg::*;
;
   typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] r;} rcf_row_s;
   typedef struct {logic [1:0] sel; logic raw; logic pat; logic exp;} rcf_src_s;
   logic clk, rst, avs_read, avs_write, avs_waitrequest, patgen_data, slow, raw_level;
   logic lock_in, pat_const, watch, pend, expd, rx_eq_data, rx_raw_data, rec_tick;
   logic cdr_lock_detect, cal_clk_in, tx_data, tx_valid, tx_mute, chk_data, chk_valid;
   logic cdr_locked;
   logic [7:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic signed [7:0] tx_fir_level;
   logic [5:0] output_swing_pkpk, output_swing_lf;
   logic [4:0] hist;
   logic [3:0] pl;
   int failures = 0, checked = 0, nt = 0, expfir, n, cpre, cmain, cpost;
   rcf_row_s rows [8] = '{
      '{IDX_TX_MAIN_TAP, 32'h0000_001f, 32'h0000_001f}, '{IDX_TX_MAIN_TAP, 32'h0000_005f, 32'h0000_005f},
      '{IDX_TX_MAIN_TAP, 32'h0000_003f, 32'h0000_001f}, '{IDX_TX_PRE_TAP, 32'h0000_004f, 32'h0000_004f},
      '{IDX_TX_PRE_TAP, 32'h0000_0014, 32'h0000_000f}, '{IDX_TX_POST_TAP, 32'h0000_007f, 32'h0000_004f},
      '{IDX_TX_POST_TAP, 32'h0000_0085, 32'h0000_0005}, '{8'h50, 32'h0000_0012, 32'h0000_0000}};
   rcf_src_s srcs [4] = '{'{2'h0, 1'b1, 1'b0, 1'b0}, '{2'h1, 1'b1, 1'b0, 1'b1},
      '{2'h2, 1'b0, 1'b1, 1'b1}, '{2'h3, 1'b1, 1'b1, 1'b0}};

   rcf_retimer_path #(.WINDOW(4)) u_rcf_retimer_path (.clk(clk), .rst(rst),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .rx_eq_data(rx_eq_data), .rx_raw_data(rx_raw_data),
      .patgen_data(patgen_data), .rec_tick(rec_tick), .cdr_lock_detect(cdr_lock_detect),
      .cal_clk_in(cal_clk_in), .tx_data(tx_data), .tx_valid(tx_valid),
      .tx_fir_level(tx_fir_level), .tx_mute(tx_mute), .output_swing_pkpk(output_swing_pkpk),
      .output_swing_lf(output_swing_lf), .chk_data(chk_data), .chk_valid(chk_valid),
      .cdr_locked(cdr_locked));
   rcf_link_partner u_rcf_link_partner (.clk(clk), .slow(slow), .raw_level(raw_level),
      .lock_in(lock_in), .rx_eq_data(rx_eq_data), .rx_raw_data(rx_raw_data),
      .rec_tick(rec_tick), .cal_clk_in(cal_clk_in), .cdr_lock_detect(cdr_lock_detect));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic give_verdict();
      if (failures == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         failures++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_sig(input string nm, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         failures++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Holds the request until waitrequest is seen low, data taken at that edge
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000);
      chk_reg(nm, e, rd);
   endtask

   // Streams with the given signed taps, fast then stalled ticks
   task automatic fir_run(input int cp, input int cm, input int cq);
      cpre = cp;
      cmain = cm;
      cpost = cq;
      watch <= 1'b1;
      repeat (40) @(posedge clk);
      slow <= 1'b1;
      repeat (40) @(posedge clk);
      watch <= 1'b0;
      slow <= 1'b0;
      chk_sig("swing pkpk", 8'd25, {2'b00, output_swing_pkpk});
   endtask

   task automatic do_reset();
      @(posedge clk);
      rst <= 1'b1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk_sig("waitrequest", 8'h01, {7'h00, avs_waitrequest});
      rd_chk("main tap", IDX_TX_MAIN_TAP, 32'h0000_0000);
      rd_chk("path ctrl", IDX_PATH_CTRL, 32'h0000_0000);
   endtask

   // Retime and history stages delay the level: pre weighs the bit two ticks old
   always @(posedge clk) begin
      if (watch && pend && nt > 4) begin
         chk_sig("tx_valid", 8'h01, {7'h00, tx_valid});
         chk_sig("fir level", expfir[7:0], tx_fir_level);
         chk_sig("tx_data", {7'h00, expd}, {7'h00, tx_data});
      end
      if (!watch) nt = 0;
      pend = watch && rec_tick;
      if (pend) begin
         hist = {hist[3:0], patgen_data};
         nt++;
         expfir = (hist[2] ? cpre : -cpre) + (hist[3] ? cmain : -cmain) +
                  (hist[4] ? cpost : -cpost);
         expd = hist[3];
      end
      pl <= {pl[2:0], pl[3] ^ pl[1]};
      patgen_data <= watch ? pl[0] : pat_const;
   end

   initial begin
      rst = 1'b1; avs_read = 1'b0; avs_write = 1'b0; avs_address = 8'h00;
      avs_writedata = 32'h0000_0000; slow = 1'b0; raw_level = 1'b0; lock_in = 1'b0;
      pat_const = 1'b0; watch = 1'b0; pend = 1'b0; patgen_data = 1'b0; pl = 4'h5;
      do_reset();
      rd_chk("post tap", IDX_TX_POST_TAP, 32'h0000_0000);
      rd_chk("manual lo", IDX_RATE_LO, 32'h0000_0000);
      rd_chk("manual hi", IDX_RATE_HI, 32'h0000_ffff);
      foreach (rows[i]) begin
         bus(1'b1, rows[i].a, rows[i].w);
         rd_chk("tap readback", rows[i].a, rows[i].r);
      end
      @(posedge clk);
      chk_sig("swing pkpk", 8'd51, {2'b00, output_swing_pkpk});
      chk_sig("swing lf", 8'd31, {2'b00, output_swing_lf});
      bus(1'b1, IDX_TX_PRE_TAP, 32'h0000_0042);
      bus(1'b1, IDX_TX_MAIN_TAP, 32'h0000_0014);
      bus(1'b1, IDX_TX_POST_TAP, 32'h0000_0043);
      bus(1'b1, IDX_PATH_CTRL, 32'h0000_0004);
      fir_run(-2, 20, -3);
      rd_chk("pre back", IDX_TX_PRE_TAP, 32'h0000_0042);
      bus(1'b1, IDX_TX_PRE_TAP, rd ^ 32'h0000_0040);
      rd_chk("main back", IDX_TX_MAIN_TAP, 32'h0000_0014);
      bus(1'b1, IDX_TX_MAIN_TAP, rd ^ 32'h0000_0040);
      rd_chk("post back", IDX_TX_POST_TAP, 32'h0000_0043);
      bus(1'b1, IDX_TX_POST_TAP, rd ^ 32'h0000_0040);
      fir_run(2, -20, 3);
      bus(1'b1, IDX_TX_PRE_TAP, 32'h0000_0001);
      bus(1'b1, IDX_TX_MAIN_TAP, 32'h0000_0017);
      bus(1'b1, IDX_TX_POST_TAP, 32'h0000_0001);
      fir_run(1, 23, 1);
      pat_const <= 1'b1;
      bus(1'b1, IDX_PATH_CTRL, 32'h0000_000c);
      n = 0;
      while (chk_valid !== 1'b1 && n < 20) begin @(posedge clk); n++; end
      chk_sig("chk_data", 8'h01, {7'h00, chk_data});
      bus(1'b1, IDX_PATH_CTRL, 32'h0000_0004);
      repeat (5) @(posedge clk);
      chk_sig("chk_valid off", 8'h00, {7'h00, chk_valid});
      foreach (srcs[i]) begin
         raw_level <= srcs[i].raw;
         pat_const <= srcs[i].pat;
         bus(1'b1, IDX_PATH_CTRL, {29'h0, 1'b1, srcs[i].sel});
         repeat (20) @(posedge clk);
         chk_sig("tx_mute", {7'h00, srcs[i].sel == 2'h3}, {7'h00, tx_mute});
         if (srcs[i].sel != 2'h3) chk_sig("tx_data src", {7'h00, srcs[i].exp}, {7'h00, tx_data});
         else chk_sig("muted level", 8'h00, tx_fir_level);
      end
      lock_in <= 1'b1;
      bus(1'b1, IDX_PATH_CTRL, 32'h0000_0000);
      repeat (200) @(posedge clk);
      rd_chk("status table", IDX_CDR_STATUS, 32'h0000_0000);
      bus(1'b1, IDX_RATE_LO, 32'h0000_0001);
      bus(1'b1, IDX_PATH_CTRL, 32'h0000_0010);
      repeat (200) @(posedge clk);
      rd_chk("status manual", IDX_CDR_STATUS, 32'h0000_0003);
      bus(1'b1, IDX_RATE_LO, 32'h0000_fff0);
      repeat (200) @(posedge clk);
      rd_chk("status narrow", IDX_CDR_STATUS, 32'h0000_0000);
      chk_sig("cdr_locked", 8'h00, {7'h00, cdr_locked});
      do_reset();
      give_verdict();
   end

   initial begin
      #50000;
      failures++;
      give_verdict();
   end
endmodule
